// ### hdl/ccr_map.svh
// Purpose: Byte addresses, bit positions, reset value and calendar limits
// Assumes: Byte-wide memory bus, 9-bit address
// Notes: Definitions only
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_ADDR_SHARED_IE 9'h001
`define CCR_ADDR_SHARED_IFG 9'h003
`define CCR_ADDR_CTL 9'h041
`define CCR_ADDR_CNT1 9'h042
`define CCR_ADDR_CNT2 9'h043
`define CCR_ADDR_CNT3 9'h044
`define CCR_ADDR_CNT4 9'h045
`define CCR_ADDR_DAY 9'h04C
`define CCR_ADDR_MON 9'h04D
`define CCR_ADDR_YL 9'h04E
`define CCR_ADDR_YH 9'h04F

`define CCR_CTL_RESET 8'h40
`define CCR_BIT_BCD 7
`define CCR_BIT_HOLD 6
`define CCR_MODE_HI 5
`define CCR_MODE_LO 4
`define CCR_EV_HI 3
`define CCR_EV_LO 2
`define CCR_BIT_IE 1
`define CCR_BIT_FLAG 0
`define CCR_BIT_SHARED 7

`define CCR_MASK_SEC_HEX 8'h3F
`define CCR_MASK_SEC_BCD 8'h7F
`define CCR_MASK_HR_HEX 8'h1F
`define CCR_MASK_HR_BCD 8'h3F
`define CCR_MASK_DOW 8'h07
`define CCR_MASK_DAY_HEX 8'h1F
`define CCR_MASK_DAY_BCD 8'h3F
`define CCR_MASK_MON_HEX 8'h0F
`define CCR_MASK_MON_BCD 8'h1F
`define CCR_MASK_YH_HEX 8'h0F
`define CCR_MASK_YH_BCD 8'h7F

`define CCR_SEC_MAX 8'h3B
`define CCR_HR_MAX 8'h17
`define CCR_HR_NOON 8'h0C
`define CCR_DOW_MAX 8'h06
`define CCR_MON_MAX 8'h0C
`define CCR_FEB_DAYS 8'h1C
`define CCR_LEAP_DAYS 8'h1D
`define CCR_FIRST 8'h01
`define CCR_YL_BCD_MAX 8'h99
`define CCR_YH_BCD_MAX 8'h49

`endif

// ### hdl/ccr_pkg.sv
// Purpose: Types shared by the calendar counter clock
// Assumes: Constants live in ccr_map.svh
// Notes: Mode enum follows the mode field order
package ccr_pkg;

  typedef logic [8:0] ccr_addr_t;

  typedef enum logic [1:0] {
    CCR_MODE_AUX,
    CCR_MODE_TAP,
    CCR_MODE_SUB,
    CCR_MODE_CAL
  } ccr_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    ccr_addr_t addr;
    logic [7:0] wdata;
  } ccr_bus_s;

  typedef struct packed {
    logic [2:0] aux;
    logic [2:0] sub;
    logic [2:0] tap;
  } ccr_sync_s;

  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0][7:0] cnt;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] dow;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] yl;
    logic [7:0] yh;
    logic ie7;
    logic ifg7;
    logic irq;
    logic halt;
    logic [7:0] rdData;
    ccr_sync_s sync;
  } ccr_state_s;

endpackage

// ### hdl/ccr_core.sv
// Purpose: Cascaded 32-bit counter / calendar clock with shared interrupt bits
// Assumes: clk_sys 125 MHz; clock sources arrive as pins and are synchronised
// Notes: One prescaler tap edge is one calendar second
`timescale 1ns/1ps
`include "ccr_map.svh"

module ccr_core (
  input logic clk_sys,
  input logic rst_n,
  input logic ce,
  input ccr_pkg::ccr_bus_s busReq,
  output logic [7:0] rdData,
  input logic auxClkPin,
  input logic subMainClkPin,
  input logic prescalerTapPin,
  input logic prescalerEvent,
  input logic irqAck,
  input logic globalIrqEnable,
  output logic irqReq,
  output logic prescalerHalt
);
  import ccr_pkg::*;

  localparam ccr_state_s ST_RESET = '{
    ctl: `CCR_CTL_RESET, cnt: '0, sec: 8'h00, min: 8'h00, hr: 8'h00, dow: 8'h00,
    day: `CCR_FIRST, mon: `CCR_FIRST, yl: 8'h00, yh: 8'h00, ie7: 1'b0, ifg7: 1'b0,
    irq: 1'b0, halt: 1'b0, rdData: 8'h00, sync: '0};

  ccr_state_s s;
  ccr_state_s n;
  ccr_mode_e mode;
  logic bcd;
  logic calMode;
  logic cntWrite;
  logic tickSrc;
  logic tickCnt;
  logic tickCal;
  logic ovf;
  logic calEv;
  logic evHit;
  logic [3:0] carry;
  logic secW;
  logic minW;
  logic hrW;
  logic dayW;
  logic monW;
  logic leap;
  logic [7:0] dim;
  logic [7:0] monB;
  logic [7:0] ylB;
  logic [7:0] hrStep;
  logic [11:0] yearHex;

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers: hex is plain binary, BCD is two nibbles

  function automatic logic [7:0] fmtOf(input logic [7:0] bin, input logic isBcd);
    logic [7:0] t;
    logic [7:0] u;
    t = bin / 8'h0A;
    u = bin % 8'h0A;
    return isBcd ? {t[3:0], u[3:0]} : bin;
  endfunction

  function automatic logic [7:0] binOf(input logic [7:0] v, input logic isBcd);
    return isBcd ? 8'({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]}) : v;
  endfunction

  function automatic logic [7:0] stepOf(input logic [7:0] v, input logic isBcd);
    if (isBcd && v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    n = s;
    bcd = s.ctl[`CCR_BIT_BCD];
    mode = ccr_mode_e'(s.ctl[`CCR_MODE_HI:`CCR_MODE_LO]);
    calMode = (mode == CCR_MODE_CAL);

    // Pin clocks: two stages before any use, third only for edge detect
    n.sync.aux = {s.sync.aux[1:0], auxClkPin};
    n.sync.sub = {s.sync.sub[1:0], subMainClkPin};
    n.sync.tap = {s.sync.tap[1:0], prescalerTapPin};

    // Writing a counting register stops the clock for that cycle
    cntWrite = busReq.wr && ((busReq.addr >= `CCR_ADDR_CNT1 && busReq.addr <= `CCR_ADDR_CNT4)
      || (busReq.addr >= `CCR_ADDR_DAY && busReq.addr <= `CCR_ADDR_YH));

    case (mode)
      CCR_MODE_AUX: tickSrc = s.sync.aux[1] & ~s.sync.aux[2];
      CCR_MODE_SUB: tickSrc = s.sync.sub[1] & ~s.sync.sub[2];
      CCR_MODE_TAP: tickSrc = s.sync.tap[1] & ~s.sync.tap[2];
      CCR_MODE_CAL: tickSrc = s.sync.tap[1] & ~s.sync.tap[2];
      default: tickSrc = 1'b0;
    endcase
    tickCnt = tickSrc & ~s.ctl[`CCR_BIT_HOLD] & ~cntWrite & ~calMode;
    tickCal = tickSrc & ~s.ctl[`CCR_BIT_HOLD] & ~cntWrite & calMode;

    // Cascaded counter
    carry[0] = (s.cnt[0] == 8'hFF);
    for (int i = 1; i < 4; i++) begin
      carry[i] = carry[i-1] & (s.cnt[i] == 8'hFF);
    end
    if (tickCnt) begin
      n.cnt[0] = s.cnt[0] + 8'h01;
      for (int i = 1; i < 4; i++) begin
        if (carry[i-1]) begin
          n.cnt[i] = s.cnt[i] + 8'h01;
        end
      end
    end
    ovf = tickCnt & carry[s.ctl[`CCR_EV_HI:`CCR_EV_LO]];

    // Calendar
    monB = binOf(s.mon, bcd);
    ylB = binOf(s.yl, bcd);
    leap = (ylB[1:0] == 2'b00);
    case (monB)
      8'h02: dim = leap ? `CCR_LEAP_DAYS : `CCR_FEB_DAYS;
      8'h04, 8'h06, 8'h09, 8'h0B: dim = 8'h1E;
      default: dim = 8'h1F;
    endcase
    secW = (s.sec == fmtOf(`CCR_SEC_MAX, bcd));
    minW = (s.min == fmtOf(`CCR_SEC_MAX, bcd));
    hrW = (s.hr == fmtOf(`CCR_HR_MAX, bcd));
    dayW = (s.day == fmtOf(dim, bcd));
    monW = (s.mon == fmtOf(`CCR_MON_MAX, bcd));
    hrStep = stepOf(s.hr, bcd);
    yearHex = {s.yh[3:0], s.yl} + 12'h001;
    if (tickCal) begin
      n.sec = secW ? 8'h00 : stepOf(s.sec, bcd);
      if (secW) begin
        n.min = minW ? 8'h00 : stepOf(s.min, bcd);
      end
      if (secW && minW) begin
        n.hr = hrW ? 8'h00 : hrStep;
      end
      if (secW && minW && hrW) begin
        n.dow = (s.dow == `CCR_DOW_MAX) ? 8'h00 : s.dow + 8'h01;
        n.day = dayW ? `CCR_FIRST : stepOf(s.day, bcd);
        if (dayW) begin
          n.mon = monW ? `CCR_FIRST : stepOf(s.mon, bcd);
        end
        if (dayW && monW) begin
          if (bcd) begin
            n.yl = (s.yl == `CCR_YL_BCD_MAX) ? 8'h00 : stepOf(s.yl, 1'b1);
            if (s.yl == `CCR_YL_BCD_MAX) begin
              n.yh = (s.yh == `CCR_YH_BCD_MAX) ? 8'h00 : stepOf(s.yh, 1'b1);
            end
          end else begin
            n.yl = yearHex[7:0];
            n.yh = {4'h0, yearHex[11:8]};
          end
        end
      end
    end
    case (s.ctl[`CCR_EV_HI:`CCR_EV_LO])
      2'b00: calEv = tickCal & secW;
      2'b01: calEv = tickCal & secW & minW;
      2'b10: calEv = tickCal & secW & minW & hrW;
      2'b11: calEv = tickCal & secW & minW & (hrStep == fmtOf(`CCR_HR_NOON, bcd));
      default: calEv = 1'b0;
    endcase
    evHit = ovf | calEv;

    // Service clears the shared flag, and the event flag only while IE is set, unless an event lands in the same cycle
    if (irqAck) begin
      n.ifg7 = 1'b0;
      if (s.ctl[`CCR_BIT_IE]) begin
        n.ctl[`CCR_BIT_FLAG] = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; masks keep unused bits at zero in each format

    if (busReq.wr) begin
      case (busReq.addr)
        `CCR_ADDR_CTL: begin
          n.ctl = busReq.wdata;
          if ((busReq.wdata[`CCR_MODE_HI:`CCR_MODE_LO] == 2'b11 && !calMode)
              || busReq.wdata[`CCR_BIT_BCD] != bcd) begin
            n.sec = 8'h00;
            n.min = 8'h00;
            n.hr = 8'h00;
            n.dow = 8'h00;
            n.yl = 8'h00;
            n.yh = 8'h00;
            n.day = `CCR_FIRST;
            n.mon = `CCR_FIRST;
          end
        end
        `CCR_ADDR_CNT1: begin
          if (calMode) begin
            n.sec = busReq.wdata & (bcd ? `CCR_MASK_SEC_BCD : `CCR_MASK_SEC_HEX);
          end else begin
            n.cnt[0] = busReq.wdata;
          end
        end
        `CCR_ADDR_CNT2: begin
          if (calMode) begin
            n.min = busReq.wdata & (bcd ? `CCR_MASK_SEC_BCD : `CCR_MASK_SEC_HEX);
          end else begin
            n.cnt[1] = busReq.wdata;
          end
        end
        `CCR_ADDR_CNT3: begin
          if (calMode) begin
            n.hr = busReq.wdata & (bcd ? `CCR_MASK_HR_BCD : `CCR_MASK_HR_HEX);
          end else begin
            n.cnt[2] = busReq.wdata;
          end
        end
        `CCR_ADDR_CNT4: begin
          if (calMode) begin
            n.dow = busReq.wdata & `CCR_MASK_DOW;
          end else begin
            n.cnt[3] = busReq.wdata;
          end
        end
        `CCR_ADDR_DAY: n.day = busReq.wdata & (bcd ? `CCR_MASK_DAY_BCD : `CCR_MASK_DAY_HEX);
        `CCR_ADDR_MON: n.mon = busReq.wdata & (bcd ? `CCR_MASK_MON_BCD : `CCR_MASK_MON_HEX);
        `CCR_ADDR_YL: n.yl = busReq.wdata;
        `CCR_ADDR_YH: n.yh = busReq.wdata & (bcd ? `CCR_MASK_YH_BCD : `CCR_MASK_YH_HEX);
        // Only bit 7 lives here; other modules own bits 6-0
        `CCR_ADDR_SHARED_IE: n.ie7 = busReq.wdata[`CCR_BIT_SHARED];
        `CCR_ADDR_SHARED_IFG: n.ifg7 = busReq.wdata[`CCR_BIT_SHARED];
        default: n.ifg7 = n.ifg7;
      endcase
    end

    // Sets come last so an event never loses to a clear
    if (evHit) begin
      n.ctl[`CCR_BIT_FLAG] = 1'b1;
      if (s.ctl[`CCR_BIT_IE]) begin
        n.ifg7 = 1'b1;
      end
    end
    if (prescalerEvent && !s.ctl[`CCR_BIT_IE]) begin
      n.ifg7 = 1'b1;
    end
    n.irq = n.ifg7 & n.ie7 & globalIrqEnable;
    n.halt = n.ctl[`CCR_BIT_HOLD] & (n.ctl[`CCR_MODE_HI:`CCR_MODE_LO] == 2'b11);

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped reads zero

    if (busReq.rd) begin
      case (busReq.addr)
        `CCR_ADDR_CTL: n.rdData = s.ctl;
        `CCR_ADDR_CNT1: n.rdData = calMode ? s.sec : s.cnt[0];
        `CCR_ADDR_CNT2: n.rdData = calMode ? s.min : s.cnt[1];
        `CCR_ADDR_CNT3: n.rdData = calMode ? s.hr : s.cnt[2];
        `CCR_ADDR_CNT4: n.rdData = calMode ? s.dow : s.cnt[3];
        `CCR_ADDR_DAY: n.rdData = s.day;
        `CCR_ADDR_MON: n.rdData = s.mon;
        `CCR_ADDR_YL: n.rdData = s.yl;
        `CCR_ADDR_YH: n.rdData = s.yh;
        `CCR_ADDR_SHARED_IE: n.rdData = {s.ie7, 7'h00};
        `CCR_ADDR_SHARED_IFG: n.rdData = {s.ifg7, 7'h00};
        default: n.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= ST_RESET;
    end else if (ce) begin
      s <= n;
    end
  end

  assign rdData = s.rdData;
  assign irqReq = s.irq;
  assign prescalerHalt = s.halt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !ce);

  sequence secWrap;
    tickCal && !busReq.wr && s.sec == fmtOf(`CCR_SEC_MAX, bcd);
  endsequence

  sequence enterCal;
    busReq.wr && busReq.addr == `CCR_ADDR_CTL
      && busReq.wdata[`CCR_MODE_HI:`CCR_MODE_LO] == 2'b11 && !calMode;
  endsequence

  // Last second of a day: seconds, minutes and hours all at their limits
  sequence dayRoll;
    secWrap ##0 s.min == fmtOf(`CCR_SEC_MAX, bcd) && s.hr == fmtOf(`CCR_HR_MAX, bcd);
  endsequence

  hold_freeze_a: assert property (s.ctl[`CCR_BIT_HOLD] && !busReq.wr
    |=> $stable(s.cnt) && $stable(s.sec))
    else $error("count moved while held");
  cascade_carry_a: assert property (tickCnt && s.cnt[0] == 8'hFF
    |=> s.cnt[0] == 8'h00 && s.cnt[1] == $past(s.cnt[1]) + 8'h01)
    else $error("byte carry not passed up");
  overflow_pick_a: assert property (tickCnt && s.cnt[0] == 8'hFF
    && s.ctl[`CCR_EV_HI:`CCR_EV_LO] == 2'b00 |=> s.ctl[`CCR_BIT_FLAG])
    else $error("8-bit overflow did not set flag");
  sec_wrap_a: assert property (secWrap |=> s.sec == 8'h00 && s.min != $past(s.min))
    else $error("seconds wrap did not carry");
  minute_event_a: assert property (secWrap
    ##0 s.ctl[`CCR_EV_HI:`CCR_EV_LO] == 2'b00 |=> s.ctl[`CCR_BIT_FLAG])
    else $error("minute change did not set flag");
  midnight_event_a: assert property (dayRoll
    ##0 s.ctl[`CCR_EV_HI:`CCR_EV_LO] == 2'b10 |=> s.hr == 8'h00 && s.ctl[`CCR_BIT_FLAG])
    else $error("midnight did not set flag");
  dow_wrap_a: assert property (dayRoll ##0 s.dow == `CCR_DOW_MAX |=> s.dow == 8'h00)
    else $error("day of week did not wrap");
  leap_day_a: assert property (dayRoll ##0 binOf(s.mon, bcd) == 8'h02
    && binOf(s.yl, bcd) % 8'h04 == 8'h00 && s.day == fmtOf(`CCR_FEB_DAYS, bcd)
    |=> s.day == fmtOf(`CCR_LEAP_DAYS, bcd))
    else $error("leap February lost its last day");
  mode_clear_a: assert property (enterCal |=> s.sec == 8'h00 && s.day == `CCR_FIRST
    && s.mon == `CCR_FIRST && s.yl == 8'h00)
    else $error("calendar not reset on entry");
  shared_set_a: assert property (evHit && s.ctl[`CCR_BIT_IE] |=> s.ifg7 && s.ctl[`CCR_BIT_FLAG])
    else $error("enabled event missed shared flag");
  ack_clear_a: assert property (irqAck && !evHit && !prescalerEvent && !busReq.wr
    |=> !s.ifg7)
    else $error("service did not clear shared flag");
  irq_gate_a: assert property (irqReq |-> s.ifg7 && s.ie7 && $past(globalIrqEnable))
    else $error("interrupt without enable and flag");
  irq_raise_a: assert property (s.ifg7 && s.ie7 && globalIrqEnable && !irqAck
    && !busReq.wr |=> irqReq)
    else $error("enabled flag raised no request");
  halt_set_a: assert property (busReq.wr && busReq.addr == `CCR_ADDR_CTL
    && busReq.wdata[`CCR_BIT_HOLD] && busReq.wdata[`CCR_MODE_HI:`CCR_MODE_LO] == 2'b11
    |=> prescalerHalt)
    else $error("calendar hold left prescaler running");
  cnt_read_a: assert property (busReq.rd && busReq.addr == `CCR_ADDR_CNT1
    && !calMode |=> rdData == $past(s.cnt[0]))
    else $error("count byte read wrong stage");
  // Own disable: the default one would switch this check off exactly when it matters
  ce_freeze_a: assert property (disable iff (!rst_n) !ce |=> $stable(s))
    else $error("state moved with clock enable low");

endmodule // ccr_core

// ### tb/ccr_core_bench.sv
// Purpose: Self-checking bench for the calendar counter clock core
// Assumes: clk_sys 8 ns; synchronous active-low reset; addresses from ccr_map.svh
// Notes: Register table first, then ticks, events, interrupts and a second reset
`timescale 1ns/1ps
`include "ccr_map.svh"

module ccr_core_bench;
  import ccr_pkg::*;

  typedef struct packed {
    logic wr;
    ccr_addr_t addr;
    logic [7:0] wdata;
    logic [7:0] expData;
  } ccr_row_s;

  typedef struct {
    logic [7:0] ctl;
    logic [7:0] setV[8];
    logic [7:0] expV[8];
    logic [7:0] ctlExp;
  } ccr_cal_s;

  localparam int NROWS = 28;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  ccr_bus_s busReq = '0;
  logic [7:0] rdData;
  logic [2:0] pins = 3'h0;
  logic prescalerEvent = 1'b0;
  logic irqAck = 1'b0;
  logic globalIrqEnable = 1'b0;
  logic irqReq;
  logic prescalerHalt;
  int numErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int srcPin[3] = '{0, 2, 1};
  ccr_addr_t calAddr[8] = '{`CCR_ADDR_CNT1, `CCR_ADDR_CNT2, `CCR_ADDR_CNT3, `CCR_ADDR_CNT4,
    `CCR_ADDR_DAY, `CCR_ADDR_MON, `CCR_ADDR_YL, `CCR_ADDR_YH};

  // First six rows double as the reset-value list
  ccr_row_s rows[NROWS] = '{
    '{1'b0, `CCR_ADDR_CTL, 8'h00, 8'h40},
    '{1'b0, `CCR_ADDR_DAY, 8'h00, 8'h01},
    '{1'b0, `CCR_ADDR_MON, 8'h00, 8'h01},
    '{1'b0, `CCR_ADDR_SHARED_IE, 8'h00, 8'h00},
    '{1'b0, `CCR_ADDR_SHARED_IFG, 8'h00, 8'h00},
    '{1'b0, `CCR_ADDR_CNT1, 8'h00, 8'h00},
    '{1'b1, `CCR_ADDR_CTL, 8'h70, 8'h70},
    '{1'b1, `CCR_ADDR_CNT1, 8'hFF, 8'h3F},
    '{1'b1, `CCR_ADDR_CNT2, 8'hFF, 8'h3F},
    '{1'b1, `CCR_ADDR_CNT3, 8'hFF, 8'h1F},
    '{1'b1, `CCR_ADDR_CNT4, 8'hFF, 8'h07},
    '{1'b1, `CCR_ADDR_DAY, 8'hFF, 8'h1F},
    '{1'b1, `CCR_ADDR_MON, 8'hFF, 8'h0F},
    '{1'b1, `CCR_ADDR_YL, 8'hFF, 8'hFF},
    '{1'b1, `CCR_ADDR_YH, 8'hFF, 8'h0F},
    '{1'b1, 9'h050, 8'hFF, 8'h00},
    '{1'b1, `CCR_ADDR_SHARED_IE, 8'h80, 8'h80},
    '{1'b1, `CCR_ADDR_CTL, 8'hF0, 8'hF0},
    '{1'b0, `CCR_ADDR_CNT1, 8'h00, 8'h00},
    '{1'b0, `CCR_ADDR_DAY, 8'h00, 8'h01},
    '{1'b0, `CCR_ADDR_MON, 8'h00, 8'h01},
    '{1'b0, `CCR_ADDR_YL, 8'h00, 8'h00},
    '{1'b1, `CCR_ADDR_CNT1, 8'hFF, 8'h7F},
    '{1'b1, `CCR_ADDR_CNT3, 8'hFF, 8'h3F},
    '{1'b1, `CCR_ADDR_DAY, 8'hFF, 8'h3F},
    '{1'b1, `CCR_ADDR_MON, 8'hFF, 8'h1F},
    '{1'b1, `CCR_ADDR_YL, 8'hFF, 8'hFF},
    '{1'b1, `CCR_ADDR_YH, 8'hFF, 8'h7F}
  };

  // Field order: sec, min, hour, weekday, day, month, year low, year high
  ccr_cal_s cal[6] = '{
    '{8'h3A, '{8'h3B, 8'h3B, 8'h17, 8'h06, 8'h1C, 8'h02, 8'h04, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1D, 8'h02, 8'h04, 8'h00}, 8'h3B},
    '{8'h3E, '{8'h3B, 8'h3B, 8'h17, 8'h06, 8'h1F, 8'h0C, 8'h05, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h06, 8'h00}, 8'h3E},
    '{8'h3E, '{8'h3B, 8'h3B, 8'h0B, 8'h02, 8'h0A, 8'h03, 8'h06, 8'h00},
      '{8'h00, 8'h00, 8'h0C, 8'h02, 8'h0A, 8'h03, 8'h06, 8'h00}, 8'h3F},
    '{8'h36, '{8'h3B, 8'h3B, 8'h17, 8'h03, 8'h1C, 8'h02, 8'h05, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h05, 8'h00}, 8'h37},
    '{8'h32, '{8'h3B, 8'h3B, 8'h17, 8'h06, 8'h1F, 8'h0C, 8'hFF, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01}, 8'h33},
    '{8'hB2, '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99, 8'h19},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h20}, 8'hB3}
  };

  ccr_core dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .busReq(busReq),
    .rdData(rdData),
    .auxClkPin(pins[0]),
    .subMainClkPin(pins[1]),
    .prescalerTapPin(pins[2]),
    .prescalerEvent(prescalerEvent),
    .irqAck(irqAck),
    .globalIrqEnable(globalIrqEnable),
    .irqReq(irqReq),
    .prescalerHalt(prescalerHalt)
  );

  always #4 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish();
    $display("Compared %0d values, %0d mismatches", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
    samplesChecked++;
    if (seen !== expd) begin
      numErrors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic wrReg(input ccr_addr_t a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    busReq = '0;
  endtask

  // Waits one spare edge so the registered read data has surely landed
  task automatic rdCheck(input ccr_addr_t a, input logic [7:0] expd, input string what);
    @(posedge clk_sys);
    #1;
    busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    busReq = '0;
    @(posedge clk_sys);
    #1;
    check(rdData, expd, what);
  endtask

  // Pin stays high and low well beyond the three-edge synchroniser
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    #1;
    pins[idx] = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    pins[idx] = 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic strobe(ref logic s);
    @(posedge clk_sys);
    #1;
    s = 1'b1;
    @(posedge clk_sys);
    #1;
    s = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      tallyAndFinish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] ctl;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check({6'h00, irqReq, prescalerHalt}, 8'h00, "outputs after reset");
    for (int i = 0; i < NROWS; i++) begin
      if (rows[i].wr) wrReg(rows[i].addr, rows[i].wdata);
      rdCheck(rows[i].addr, rows[i].expData, "register row");
    end
    for (int m = 0; m < 3; m++) begin
      wrReg(`CCR_ADDR_CTL, 8'(m << 4));
      wrReg(`CCR_ADDR_CNT1, 8'h00);
      pulse(srcPin[(m + 1) % 3]);
      pulse(srcPin[m]);
      rdCheck(`CCR_ADDR_CNT1, 8'h01, "mode clock source");
    end
    wrReg(`CCR_ADDR_CTL, 8'h40);
    wrReg(`CCR_ADDR_CNT1, 8'h05);
    pulse(0);
    rdCheck(`CCR_ADDR_CNT1, 8'h05, "held counter");
    check({7'h00, prescalerHalt}, 8'h00, "counter hold leaves prescaler");
    // Lower overflows first must not fire the higher selection
    for (int e = 0; e < 4; e++) begin
      ctl = 8'(e << 2) | 8'h02;
      wrReg(`CCR_ADDR_SHARED_IFG, 8'h00);
      wrReg(`CCR_ADDR_CTL, ctl);
      for (int k = 0; k < 4; k++) wrReg(ccr_addr_t'(`CCR_ADDR_CNT1 + k), (k < e) ? 8'hFF : 8'h00);
      pulse(0);
      rdCheck(`CCR_ADDR_CTL, ctl, "no event below selection");
      for (int k = 0; k <= e; k++) wrReg(ccr_addr_t'(`CCR_ADDR_CNT1 + k), 8'hFF);
      pulse(0);
      rdCheck(`CCR_ADDR_CTL, ctl | 8'h01, "overflow event");
      rdCheck(`CCR_ADDR_SHARED_IFG, 8'h80, "shared flag");
      rdCheck(ccr_addr_t'(`CCR_ADDR_CNT1 + e), 8'h00, "byte wrap");
      if (e < 3) rdCheck(ccr_addr_t'(`CCR_ADDR_CNT1 + e + 1), 8'h01, "carry");
    end
    check({7'h00, irqReq}, 8'h00, "globally masked");
    globalIrqEnable = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({7'h00, irqReq}, 8'h01, "request raised");
    wrReg(`CCR_ADDR_SHARED_IE, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, irqReq}, 8'h00, "shared enable off");
    wrReg(`CCR_ADDR_SHARED_IE, 8'h80);
    strobe(irqAck);
    rdCheck(`CCR_ADDR_SHARED_IFG, 8'h00, "serviced shared flag");
    rdCheck(`CCR_ADDR_CTL, 8'h0E, "serviced event flag");
    check({7'h00, irqReq}, 8'h00, "request dropped");
    wrReg(`CCR_ADDR_CTL, 8'h00);
    strobe(prescalerEvent);
    rdCheck(`CCR_ADDR_SHARED_IFG, 8'h80, "prescaler event");
    wrReg(`CCR_ADDR_SHARED_IFG, 8'h00);
    rdCheck(`CCR_ADDR_SHARED_IFG, 8'h00, "software clear");
    wrReg(`CCR_ADDR_CTL, 8'h02);
    strobe(prescalerEvent);
    rdCheck(`CCR_ADDR_SHARED_IFG, 8'h00, "prescaler event ignored");
    wrReg(`CCR_ADDR_CTL, 8'h70);
    rdCheck(`CCR_ADDR_MON, 8'h01, "calendar entry");
    check({7'h00, prescalerHalt}, 8'h01, "calendar hold");
    for (int r = 0; r < 6; r++) begin
      wrReg(`CCR_ADDR_CTL, cal[r].ctl);
      for (int i = 0; i < 8; i++) wrReg(calAddr[i], cal[r].setV[i]);
      pulse(2);
      for (int i = 0; i < 8; i++) rdCheck(calAddr[i], cal[r].expV[i], "field");
      rdCheck(`CCR_ADDR_CTL, cal[r].ctlExp, "calendar event");
    end
    check({7'h00, prescalerHalt}, 8'h00, "calendar running");
    // Clock enable low hides a whole tap pulse, synchronisers included
    ce = 1'b0;
    pulse(2);
    #1;
    ce = 1'b1;
    rdCheck(`CCR_ADDR_CNT1, 8'h00, "frozen by clock enable");
    @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rdCheck(rows[i].addr, rows[i].expData, "second reset");
    check({6'h00, irqReq, prescalerHalt}, 8'h00, "outputs after second reset");
    tallyAndFinish();
  end

endmodule // ccr_core_bench
